/* design/eevs_scrub.sv */
// enclave exit scrubber for the vm_control_structure write path
// assumes exit path and structure storage share ref_clk_i
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "eevs_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module eevs_scrub (
	input  wire logic                ref_clk_i,      // core clock
	input  wire logic                arst_n_i,       // async reset
	input  wire logic                ce_i,           // clock enable
	input  wire eevs_pkg::eevs_exit_s exit_i,        // raw exit record
	input  wire eevs_pkg::eevs_gpr_s synth_i,        // synthetic regs
	input  wire logic                exit_valid_i,   // record offered
	output logic                     exit_ready_o,   // record taken
	output eevs_pkg::eevs_exit_s     rec_o,          // scrubbed record
	output logic                     rec_valid_o,    // record ready
	input  wire logic                rec_ready_i,    // storage takes it
	input  wire logic                s_axi_awvalid,  // write address
	output logic                     s_axi_awready,  // address taken
	input  wire logic [7:0]          s_axi_awaddr,   // byte address
	input  wire logic                s_axi_wvalid,   // write data
	output logic                     s_axi_wready,   // data taken
	input  wire logic [31:0]         s_axi_wdata,    // data
	input  wire logic [3:0]          s_axi_wstrb,    // byte enables
	output logic                     s_axi_bvalid,   // write answer
	input  wire logic                s_axi_bready,   // answer taken
	output logic [1:0]               s_axi_bresp,    // write status
	input  wire logic                s_axi_arvalid,  // read address
	output logic                     s_axi_arready,  // address taken
	input  wire logic [7:0]          s_axi_araddr,   // byte address
	output logic                     s_axi_rvalid,   // read answer
	input  wire logic                s_axi_rready,   // answer taken
	output logic [31:0]              s_axi_rdata,    // read data
	output logic [1:0]               s_axi_rresp,    // read status
	output logic                     irq_o           // level interrupt
);

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic                     accept_en;    // software lets exits in
	logic [15:0]              encl_count;   // enclave exits seen
	logic [`EEVS_IRQ_W-1:0]   irq_stat;     // sticky events
	logic [`EEVS_IRQ_W-1:0]   irq_mask;     // event enables
	logic [`EEVS_IRQ_W-1:0]   irq_set;      // events this cycle
	logic                     take;         // record accepted
	eevs_pkg::eevs_exit_s     next_rec;     // scrubbed value
	logic                     aw_held;      // address waiting
	logic                     w_held;       // data waiting
	logic [7:0]               aw_addr;      // held address
	logic [31:0]              w_data;       // held data
	logic [3:0]               w_strb;       // held byte enables
	logic                     wr_do;        // both halves present
	logic                     wr_hit;       // address is mapped
	logic [31:0]              wr_bits;      // data under strobes
	logic [31:0]              rd_word;      // read mux result
	logic                     rd_hit;       // read address mapped

	// --------------------------------------------------------------
	// exit record path
	// --------------------------------------------------------------

	// one record in flight; the stage frees as the storage takes it.
	// ready is held low while disabled so no exit slips past unscrubbed
	assign exit_ready_o = ce_i & accept_en & (~rec_valid_o | rec_ready_i);
	assign take         = exit_valid_i & exit_ready_o;

	// scrub: enclave exits are rewritten, others pass as offered with the basic_info enclave bit cleared
	always_comb begin
		next_rec = exit_i;
		next_rec.basic_info[`EEVS_BASIC_ENCL_BIT] = exit_i.in_enclave;
		if (exit_i.in_enclave) begin
			next_rec.gpr = synth_i;
			next_rec.intr_state[`EEVS_INTR_ENCL_BIT] = 1'b1;
			// delivery-time faults keep the low bits: the exit that
			// hides them runs before the delivery fault is recorded
			if (!exit_i.in_delivery) begin
				if (exit_i.cause == eevs_pkg::EEVS_CAUSE_NPT_VIOL &&
				    exit_i.qual[`EEVS_QUAL_LA_BIT]) begin
					next_rec.gla = exit_i.gla & `EEVS_PAGE_LOW_MASK;
				end
				if (exit_i.cause == eevs_pkg::EEVS_CAUSE_NPT_VIOL ||
				    exit_i.cause == eevs_pkg::EEVS_CAUSE_NPT_MISCFG) begin
					next_rec.gpa = exit_i.gpa & `EEVS_PAGE_LOW_MASK;
				end
				if (exit_i.cause == eevs_pkg::EEVS_CAUSE_PAGE_FAULT) begin
					next_rec.qual = exit_i.qual & `EEVS_PAGE_LOW_MASK;
				end
				if (exit_i.cause == eevs_pkg::EEVS_CAUSE_LIC_ACCESS) begin
					next_rec.qual = exit_i.qual & `EEVS_PAGE_LOW_MASK;
				end
			end
			next_rec.instr_len = `EEVS_ZERO32;
			next_rec.io_rcx    = `EEVS_ZERO64;
			next_rec.io_rsi    = `EEVS_ZERO64;
			next_rec.io_rdi    = `EEVS_ZERO64;
			next_rec.io_rip    = `EEVS_ZERO64;
			// breakpoints are fault-like here, so they fall to zero too
			if (exit_i.cause != eevs_pkg::EEVS_CAUSE_INSTR_LISTED) begin
				next_rec.instr_info = `EEVS_ZERO32;
			end
			if (exit_i.cause == eevs_pkg::EEVS_CAUSE_BREAKPOINT) begin
				next_rec.intr_type = `EEVS_TYPE_HW_EXC;
			end
		end
	end

	// record register and its valid flag
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rec_o       <= '0;
			rec_valid_o <= 1'b0;
		end else if (ce_i) begin
			if (take) begin
				rec_o       <= next_rec;
				rec_valid_o <= 1'b1;
			end else if (rec_ready_i) begin
				rec_valid_o <= 1'b0;
			end
		end
	end

	// enclave exit counter, wraps silently
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			encl_count <= '0;
		end else if (ce_i && take && exit_i.in_enclave) begin
			encl_count <= encl_count + 16'h0001;
		end
	end

	// --------------------------------------------------------------
	// interrupts
	// --------------------------------------------------------------

	// events: a scrubbed enclave exit, or a plain exit passed through
	always_comb begin
		irq_set = '0;
		irq_set[`EEVS_IRQ_ENCL]  = take & exit_i.in_enclave;
		irq_set[`EEVS_IRQ_PLAIN] = take & ~exit_i.in_enclave;
	end

	// write-one-to-clear; a new event in the clearing cycle survives
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_stat <= '0;
		end else if (ce_i) begin
			if (wr_do && aw_addr == `EEVS_OFF_IRQ_STAT) begin
				irq_stat <= (irq_stat & ~wr_bits[`EEVS_IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat <= irq_stat | irq_set;
			end
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// --------------------------------------------------------------
	// register bus: write side
	// --------------------------------------------------------------

	// address and data are taken apart and joined before the answer
	assign s_axi_awready = ce_i & ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ce_i & ~w_held & ~s_axi_bvalid;
	assign wr_do         = aw_held & w_held & ~s_axi_bvalid;
	assign wr_bits       = w_data & {{8{w_strb[3]}}, {8{w_strb[2]}},
	                                 {8{w_strb[1]}}, {8{w_strb[0]}}};
	assign wr_hit        = aw_addr == `EEVS_OFF_CTRL ||
	                       aw_addr == `EEVS_OFF_STATUS ||
	                       aw_addr == `EEVS_OFF_IRQ_STAT ||
	                       aw_addr == `EEVS_OFF_IRQ_MASK;

	// hold the two halves until both have arrived
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end else if (ce_i) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_do) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_do) begin
				w_held <= 1'b0;
			end
		end
	end

	// write answer; status is read-only so writes to it are dropped
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `EEVS_RESP_OKAY;
		end else if (ce_i) begin
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `EEVS_RESP_OKAY : `EEVS_RESP_DECERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control and mask; only byte lane 0 carries bits
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			accept_en <= `EEVS_CTRL_RST;
			irq_mask  <= '0;
		end else if (ce_i && wr_do && w_strb[0]) begin
			if (aw_addr == `EEVS_OFF_CTRL) begin
				accept_en <= w_data[0];
			end
			if (aw_addr == `EEVS_OFF_IRQ_MASK) begin
				irq_mask <= w_data[`EEVS_IRQ_W-1:0];
			end
		end
	end

	// --------------------------------------------------------------
	// register bus: read side
	// --------------------------------------------------------------

	// read mux, reserved bits read zero
	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr)
			`EEVS_OFF_CTRL:     rd_word[0] = accept_en;
			`EEVS_OFF_STATUS:   rd_word[16:0] = {rec_valid_o, encl_count};
			`EEVS_OFF_IRQ_STAT: rd_word[`EEVS_IRQ_W-1:0] = irq_stat;
			`EEVS_OFF_IRQ_MASK: rd_word[`EEVS_IRQ_W-1:0] = irq_mask;
			default:            rd_hit = 1'b0;
		endcase
	end

	assign s_axi_arready = ce_i & ~s_axi_rvalid;

	// one read at a time, answered the cycle after the address
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `EEVS_RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_hit ? `EEVS_RESP_OKAY : `EEVS_RESP_DECERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------

	a_synth_regs_used: assert property (
		take && exit_i.in_enclave |=> rec_o.gpr == $past(synth_i))
		else $error("saved registers not synthetic");

	a_intr_encl_set: assert property (
		take && exit_i.in_enclave |=> rec_o.intr_state[`EEVS_INTR_ENCL_BIT])
		else $error("interruptibility enclave bit not set");

	a_basic_encl_bit: assert property (
		take |=> rec_o.basic_info[`EEVS_BASIC_ENCL_BIT] ==
		         $past(exit_i.in_enclave))
		else $error("basic exit enclave bit wrong");

	a_gla_low_clear: assert property (
		take && exit_i.in_enclave && !exit_i.in_delivery &&
		exit_i.cause == eevs_pkg::EEVS_CAUSE_NPT_VIOL &&
		exit_i.qual[`EEVS_QUAL_LA_BIT] |=> rec_o.gla[11:0] == 12'h000)
		else $error("linear address low bits kept");

	a_delivery_keeps: assert property (
		take && exit_i.in_delivery |=> rec_o.gla == $past(exit_i.gla) &&
		rec_o.gpa == $past(exit_i.gpa) && rec_o.qual == $past(exit_i.qual))
		else $error("delivery-time address altered");

	a_gpa_low_clear: assert property (
		take && exit_i.in_enclave && !exit_i.in_delivery &&
		(exit_i.cause == eevs_pkg::EEVS_CAUSE_NPT_VIOL ||
		 exit_i.cause == eevs_pkg::EEVS_CAUSE_NPT_MISCFG)
		|=> rec_o.gpa[11:0] == 12'h000 &&
		    rec_o.gpa[63:12] == $past(exit_i.gpa[63:12]))
		else $error("physical address low bits kept");

	a_qual_low_clear: assert property (
		take && exit_i.in_enclave && !exit_i.in_delivery &&
		(exit_i.cause == eevs_pkg::EEVS_CAUSE_PAGE_FAULT ||
		 exit_i.cause == eevs_pkg::EEVS_CAUSE_LIC_ACCESS)
		|=> rec_o.qual[11:0] == 12'h000)
		else $error("qualification low bits kept");

	a_len_io_zero: assert property (
		take && exit_i.in_enclave |=> rec_o.instr_len == `EEVS_ZERO32 &&
		(rec_o.io_rcx | rec_o.io_rsi | rec_o.io_rdi | rec_o.io_rip) ==
		`EEVS_ZERO64)
		else $error("length or i/o context not cleared");

	a_info_rule: assert property (
		take && exit_i.in_enclave |=> rec_o.instr_info ==
		($past(exit_i.cause) == eevs_pkg::EEVS_CAUSE_INSTR_LISTED ?
		 $past(exit_i.instr_info) : `EEVS_ZERO32))
		else $error("instruction information wrong");

	a_bp_hw_type: assert property (
		take && exit_i.in_enclave &&
		exit_i.cause == eevs_pkg::EEVS_CAUSE_BREAKPOINT
		|=> rec_o.intr_type == `EEVS_TYPE_HW_EXC)
		else $error("breakpoint type not hardware exception");

	a_rec_holds: assert property (
		rec_valid_o && !rec_ready_i |=> rec_valid_o && $stable(rec_o))
		else $error("record dropped before taken");

	// the status count moves by exactly one per enclave exit
	a_count_step: assert property (
		take && exit_i.in_enclave |=>
		encl_count == $past(encl_count) + 16'h0001)
		else $error("enclave exit count did not step");

	// records from outside an enclave keep gpr, qual, instr_info and intr_type as offered
	a_plain_passes: assert property (
		take && !exit_i.in_enclave |=> rec_o.gpr == $past(exit_i.gpr) &&
		rec_o.qual == $past(exit_i.qual) &&
		rec_o.instr_info == $past(exit_i.instr_info) &&
		rec_o.intr_type == $past(exit_i.intr_type))
		else $error("plain exit record altered");

	// a frozen block keeps its record, valid flag, interrupt status and count
	a_ce_freeze: assert property (
		!ce_i |=> $stable(rec_o) && $stable(rec_valid_o) &&
		$stable(irq_stat) && $stable(encl_count))
		else $error("state moved while clock enable low");

	// an event is never lost, even to a clear in the same cycle
	a_irq_set_wins: assert property (
		ce_i && irq_set != '0 |=> (irq_stat & $past(irq_set)) ==
		$past(irq_set))
		else $error("interrupt event lost");

	// the write answer follows the joined halves by one cycle
	a_wr_answer: assert property (
		ce_i && wr_do |=> s_axi_bvalid)
		else $error("write answer missing");

	// the write answer stands until it is taken
	a_b_holds: assert property (
		s_axi_bvalid && !(ce_i && s_axi_bready) |=> s_axi_bvalid &&
		$stable(s_axi_bresp))
		else $error("write answer dropped before taken");

	// a read is answered the cycle after its address
	a_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");

	// the read answer stands until it is taken
	a_r_holds: assert property (
		s_axi_rvalid && !(ce_i && s_axi_rready) |=> s_axi_rvalid &&
		$stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped before taken");

endmodule

`default_nettype wire

/* design/eevs_regs.svh */
// constants for the enclave exit control structure scrubber
// assumes inclusion by bare name from the scrubber and the bench
`ifndef EEVS_REGS_SVH
`define EEVS_REGS_SVH

// --------------------------------------------------------------
// control structure field layout
// --------------------------------------------------------------
`define EEVS_INTR_ENCL_BIT  4
`define EEVS_BASIC_ENCL_BIT 27
`define EEVS_QUAL_LA_BIT    7
`define EEVS_PAGE_LOW_MASK  64'hffff_ffff_ffff_f000
`define EEVS_TYPE_HW_EXC    3'h3
`define EEVS_ZERO32         32'h0000_0000
`define EEVS_ZERO64         64'h0000_0000_0000_0000

// --------------------------------------------------------------
// register map (byte addresses)
// --------------------------------------------------------------
`define EEVS_ADDR_W         8
`define EEVS_OFF_CTRL       8'h00
`define EEVS_OFF_STATUS     8'h04
`define EEVS_OFF_IRQ_STAT   8'h08
`define EEVS_OFF_IRQ_MASK   8'h0c
`define EEVS_CTRL_RST       1'h1
`define EEVS_IRQ_W          2
`define EEVS_IRQ_ENCL       0
`define EEVS_IRQ_PLAIN      1
`define EEVS_RESP_OKAY      2'h0
`define EEVS_RESP_DECERR    2'h3

`endif

/* design/eevs_pkg.sv */
// types shared by the scrubber and its bench
// assumes the field constants header sits beside it
package eevs_pkg;

	// cause of the exit as classified by the exit path
	typedef enum logic [2:0] {
		EEVS_CAUSE_OTHER,        // anything not listed below
		EEVS_CAUSE_PAGE_FAULT,   // page fault
		EEVS_CAUSE_NPT_VIOL,     // nested_page_table violation
		EEVS_CAUSE_NPT_MISCFG,   // nested_page_table misconfiguration
		EEVS_CAUSE_LIC_ACCESS,   // local_interrupt_controller page access
		EEVS_CAUSE_INSTR_LISTED, // debug, virtualization or tsc instruction
		EEVS_CAUSE_BREAKPOINT    // breakpoint_trap_instruction
	} eevs_cause_e;

	// guest registers written into the structure
	typedef struct packed {
		logic [63:0] rip;    // instruction pointer
		logic [63:0] rsp;    // stack pointer
		logic [63:0] rflags; // flags
	} eevs_gpr_s;

	// one exit record, before or after scrubbing
	typedef struct packed {
		logic        in_enclave;  // exit interrupted enclave code
		logic        in_delivery; // arose while delivering an event
		eevs_cause_e cause;       // exit cause class
		logic [2:0]  intr_type;   // interruption type
		logic [31:0] intr_state;  // guest interruptibility state
		logic [31:0] basic_info;  // basic exit information
		logic [31:0] instr_len;   // exit instruction length
		logic [31:0] instr_info;  // exit instruction information
		logic [63:0] gla;         // guest-linear address
		logic [63:0] gpa;         // guest-physical address
		logic [63:0] qual;        // exit qualification
		logic [63:0] io_rcx;      // saved i/o count
		logic [63:0] io_rsi;      // saved i/o source index
		logic [63:0] io_rdi;      // saved i/o destination index
		logic [63:0] io_rip;      // saved i/o instruction pointer
		eevs_gpr_s   gpr;         // guest registers
	} eevs_exit_s;

endpackage

/* bench/eevs_store.sv */
// storage model that takes scrubbed records from the scrubber
// assumes the scrubber and this model share ref_clk_i and arst_n_i
`timescale 1ns/1ns
`default_nettype none

module eevs_store (
	input  wire logic                 ref_clk_i, // core clock
	input  wire logic                 arst_n_i,  // async reset
	input  wire logic                 stall_i,   // hold off taking
	input  wire eevs_pkg::eevs_exit_s rec_i,     // offered record
	input  wire logic                 valid_i,   // record offered
	output logic                      ready_o,   // record taken
	output eevs_pkg::eevs_exit_s      last_o,    // last stored record
	output logic [15:0]               count_o    // records stored
);
	// a stalled store refuses everything, as a busy one would
	assign ready_o = ~stall_i;

	// capture each record on its handshake edge only
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			last_o  <= '0;
			count_o <= 16'h0000;
		end else if (valid_i && ready_o) begin
			last_o  <= rec_i;
			count_o <= count_o + 16'h0001;
		end
	end
endmodule
`default_nettype wire

/* bench/tb_enclave_exit_vm_state_scrub.sv */
// self-checking bench for the enclave exit scrubber
// assumes package, scrubber and storage model are compiled before it
`include "eevs_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_enclave_exit_vm_state_scrub;
	logic ref_clk_i, arst_n_i, ce_i, exit_valid_i, exit_ready_o;
	logic rec_valid_o, rec_ready_i, stall, irq_o;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [7:0]           s_axi_awaddr, s_axi_araddr;
	logic [31:0]          s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]           s_axi_wstrb;
	logic [1:0]           s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0]          stored_cnt;
	eevs_pkg::eevs_exit_s exit_i, rec_o, stored, r;
	eevs_pkg::eevs_gpr_s  synth_i;
	int                   fails, num_checks;

	eevs_scrub dut (.ref_clk_i, .arst_n_i, .ce_i, .exit_i, .synth_i,
		.exit_valid_i, .exit_ready_o, .rec_o, .rec_valid_o, .rec_ready_i,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .irq_o);
	eevs_store store (.ref_clk_i, .arst_n_i, .stall_i(stall), .rec_i(rec_o),
		.valid_i(rec_valid_o), .ready_o(rec_ready_i), .last_o(stored),
		.count_o(stored_cnt));

	// free-running core clock, 4 ns period
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	// --------------------------------------------------------------
	// report, compare and bus tasks
	// --------------------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [287:0] e,
		input logic [287:0] g);
		num_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", what, e, g);
			fails++;
		end
	endtask

	// a wait that runs out ends the run as a mismatch
	task automatic ran_out;
		fails++;
		$display("BAD handshake expected answer seen timeout");
		give_verdict();
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (int i = 0; i <= 50; i++) begin
			if (i == 50) ran_out();
			@(posedge ref_clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rsp = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (int i = 0; i <= 50; i++) begin
			if (i == 50) ran_out();
			@(posedge ref_clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd  = s_axi_rdata;
				rsp = s_axi_rresp;
				break;
			end
		end
		s_axi_rready <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	// offer one exit record; optionally wait until storage holds it
	task automatic send(input eevs_pkg::eevs_exit_s x, input bit wt);
		logic [15:0] c0;
		c0 = stored_cnt;
		exit_i       <= x;
		exit_valid_i <= 1'b1;
		for (int i = 0; i <= 50; i++) begin
			if (i == 50) ran_out();
			@(posedge ref_clk_i);
			if (exit_ready_o) break;
		end
		exit_valid_i <= 1'b0;
		for (int i = 0; wt && i <= 50; i++) begin
			if (i == 50) ran_out();
			@(posedge ref_clk_i);
			if (stored_cnt != c0) break;
		end
		@(posedge ref_clk_i);
	endtask

	// what the hypervisor should see, worked out field by field
	function automatic eevs_pkg::eevs_exit_s expect_rec(
		input eevs_pkg::eevs_exit_s x, input eevs_pkg::eevs_gpr_s s);
		eevs_pkg::eevs_exit_s y;
		y = x;
		y.basic_info[`EEVS_BASIC_ENCL_BIT] = x.in_enclave;
		if (x.in_enclave) begin
			y.gpr = s;
			y.intr_state[`EEVS_INTR_ENCL_BIT] = 1'b1;
			y.instr_len = 32'h0000_0000;
			y.io_rcx = '0;
			y.io_rsi = '0;
			y.io_rdi = '0;
			y.io_rip = '0;
			if (x.cause != eevs_pkg::EEVS_CAUSE_INSTR_LISTED) y.instr_info = '0;
			if (x.cause == eevs_pkg::EEVS_CAUSE_BREAKPOINT) y.intr_type = 3'h3;
			// faults met while delivering the event keep their low bits
			if (!x.in_delivery) begin
				if (x.cause == eevs_pkg::EEVS_CAUSE_NPT_VIOL && x.qual[7])
					y.gla[11:0] = 12'h000;
				if (x.cause inside {eevs_pkg::EEVS_CAUSE_NPT_VIOL,
					eevs_pkg::EEVS_CAUSE_NPT_MISCFG}) y.gpa[11:0] = 12'h000;
				if (x.cause inside {eevs_pkg::EEVS_CAUSE_PAGE_FAULT,
					eevs_pkg::EEVS_CAUSE_LIC_ACCESS}) y.qual[11:0] = 12'h000;
			end
		end
		return y;
	endfunction

	task automatic check_rec(input eevs_pkg::eevs_exit_s e,
		input eevs_pkg::eevs_exit_s g);
		chk("gpr", e.gpr, g.gpr);
		chk("intr_state", e.intr_state, g.intr_state);
		chk("basic_info", e.basic_info, g.basic_info);
		chk("gla", e.gla, g.gla);
		chk("gpa", e.gpa, g.gpa);
		chk("qual", e.qual, g.qual);
		chk("len_io", {e.instr_len, e.io_rcx, e.io_rsi, e.io_rdi, e.io_rip},
			{g.instr_len, g.io_rcx, g.io_rsi, g.io_rdi, g.io_rip});
		chk("instr_info", e.instr_info, g.instr_info);
		chk("intr_type", e.intr_type, g.intr_type);
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		fails = 0;
		num_checks = 0;
		arst_n_i = 1'b0;
		ce_i = 1'b1;
		stall = 1'b0;
		exit_valid_i = 1'b0;
		exit_i = '0;
		synth_i = {64'h5a5a_0000_0000_1000, 64'h5a5a_0000_0000_2000,
			64'h0000_0000_0000_0002};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		repeat (16) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		@(posedge ref_clk_i);
		axi_rd(`EEVS_OFF_CTRL);
		chk("ctrl", 32'h0000_0001, rd);
		axi_rd(`EEVS_OFF_IRQ_MASK);
		chk("mask", 32'h0000_0000, rd);
		$display("test reset values done");
		// every cause, in and out of enclave, with and without delivery
		for (int k = 0; k < 56; k++) begin
			r = '0;
			r.in_enclave = k[2];
			r.in_delivery = k[1];
			r.cause = eevs_pkg::eevs_cause_e'(k[5:3]);
			r.intr_type = 3'h6;
			r.intr_state = 32'h0000_0001;
			r.basic_info = {4'h0, ~k[2], 27'h000_0030};
			r.instr_len = 32'h0000_0003;
			r.instr_info = 32'h1234_5678;
			r.gla = 64'h7fff_0000_1234_5abc;
			r.gpa = 64'h0000_0001_2345_6def;
			r.qual = 64'h0abc_def0_1234_5e7f;
			r.qual[7] = k[0];
			r.io_rcx = 64'h0000_0000_0000_0011;
			r.io_rsi = 64'h0000_0000_0000_0022;
			r.io_rdi = 64'h0000_0000_0000_0033;
			r.io_rip = 64'h0000_0000_0000_0044;
			r.gpr = {3{64'h0123_4567_89ab_cdef}};
			send(r, 1'b1);
			check_rec(expect_rec(r, synth_i), stored);
		end
		$display("test scrub table done");
		// a stalled store holds the record and refuses the next one
		stall <= 1'b1;
		r.cause = eevs_pkg::EEVS_CAUSE_PAGE_FAULT;
		r.in_enclave = 1'b1;
		r.in_delivery = 1'b0;
		send(r, 1'b0);
		chk("held ready", 1'b0, exit_ready_o);
		axi_rd(`EEVS_OFF_STATUS);
		chk("status", 32'h0001_001d, rd);
		stall <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		check_rec(expect_rec(r, synth_i), stored);
		// a write with lane 0 disabled leaves control alone
		s_axi_wstrb <= 4'he;
		axi_wr(`EEVS_OFF_CTRL, 32'h0000_0000);
		s_axi_wstrb <= 4'hf;
		axi_rd(`EEVS_OFF_CTRL);
		chk("ctrl lane off", 32'h0000_0001, rd);
		axi_wr(`EEVS_OFF_CTRL, 32'h0000_0000);
		chk("off ready", 1'b0, exit_ready_o);
		axi_wr(`EEVS_OFF_CTRL, 32'h0000_0001);
		$display("test back pressure done");
		// both exit kinds were seen; mask, raise and clear
		axi_rd(`EEVS_OFF_IRQ_STAT);
		chk("irq_stat", 32'h0000_0003, rd);
		chk("irq masked", 1'b0, irq_o);
		axi_wr(`EEVS_OFF_IRQ_MASK, 32'h0000_0001);
		chk("irq raised", 1'b1, irq_o);
		axi_wr(`EEVS_OFF_IRQ_STAT, 32'h0000_0001);
		chk("irq cleared", 1'b0, irq_o);
		axi_rd(`EEVS_OFF_IRQ_STAT);
		chk("irq_stat left", 32'h0000_0002, rd);
		axi_wr(`EEVS_OFF_STATUS, 32'hffff_ffff);
		chk("status wr resp", `EEVS_RESP_OKAY, rsp);
		axi_rd(`EEVS_OFF_STATUS);
		chk("status kept", 32'h0000_001d, rd);
		axi_wr(8'h10, 32'h0000_0001);
		chk("unmapped wr", `EEVS_RESP_DECERR, rsp);
		axi_rd(8'h10);
		chk("unmapped rd", {`EEVS_RESP_DECERR, 32'h0000_0000}, {rsp, rd});
		$display("test registers done");
		// an exit offered while frozen waits until the clock enable returns
		ce_i <= 1'b0;
		fork
			send(r, 1'b1);
			begin
				repeat (4) @(posedge ref_clk_i);
				chk("frozen ready", 1'b0, exit_ready_o);
				chk("frozen store", 16'h0039, stored_cnt);
				ce_i <= 1'b1;
			end
		join
		chk("thawed store", 16'h003a, stored_cnt);
		check_rec(expect_rec(r, synth_i), stored);
		$display("test clock enable done");
		give_verdict();
	end
endmodule
`default_nettype wire
